// ==== verification/charger_ctl_asserts.sv ====
/* Checker for charger_ctl pins and gating.
 Assumes pin inputs pass a two-flop sync, so effects land within 4 cycles. */
`timescale 1ns/1ps
module charger_ctl_asserts (
  input wire       clk_sys,
  input wire       nrst,
  input wire       source_select_in,
  input wire       boost_select_in,
  input wire       charge_enable_n_in,
  input wire       ship_exit_in,
  input wire       thermistor_sense,
  input wire       charge_done_in,
  input wire       fault_in,
  input wire       stat_out,
  input wire       stat_oe,
  input wire       alert_out,
  input wire       alert_oe,
  input wire       charge_en_out,
  input wire       boost_en_out,
  input wire [2:0] input_current_limit,
  input wire       battery_switch
);
  reg [13:0] alert_cnt;
  reg [16:0] ship_cnt;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // ship_cnt saturates so a long hold cannot wrap into a false fail
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      alert_cnt <= 14'h0000;
      ship_cnt  <= 17'h0_0000;
    end else begin
      alert_cnt <= alert_oe ? alert_cnt + 14'h0001 : 14'h0000;
      if (!ship_exit_in) begin
        ship_cnt <= 17'h0_0000;
      end else if (ship_cnt != 17'h1_ffff) begin
        ship_cnt <= ship_cnt + 17'h0_0001;
      end
    end
  end
  a_open_drain: assert property (!stat_out && !alert_out)
    else $error("open drain pin driven high");
  a_done_release: assert property ((charge_done_in && !fault_in)[*5] |-> !stat_oe)
    else $error("status pin low after charge done");
  a_fault_blink: assert property (!fault_in ##1 fault_in[*6] |-> stat_oe)
    else $error("fault blink does not start low");
  a_alert_width: assert property ($fell(alert_oe) |-> $past(alert_cnt) == 14'h31ff)
    else $error("alert pulse length wrong");
  a_alert_bound: assert property (alert_oe |-> alert_cnt < 14'h3200)
    else $error("alert pulse too long");
  a_charge_gate: assert property (charge_enable_n_in[*5] |-> !charge_en_out)
    else $error("charging with enable pin high");
  a_boost_gate: assert property (!boost_select_in[*5] |-> !boost_en_out)
    else $error("boost with select low");
  a_temp_gate: assert property (!thermistor_sense[*5] |-> !charge_en_out && !boost_en_out)
    else $error("active with temperature out of window");
  a_usb_low: assert property ((source_select_in && !boost_select_in)[*5]
    |-> input_current_limit == 3'h0) else $error("usb low limit wrong");
  a_usb_high: assert property ((source_select_in && boost_select_in)[*5]
    |-> input_current_limit <= 3'h2) else $error("usb high limit above 500");
  a_ship_hold: assert property ($rose(battery_switch) |-> ship_cnt >= 17'h1_86a0)
    else $error("battery switch on too early");
  a_switch_sticky: assert property (battery_switch |=> battery_switch)
    else $error("battery switch dropped");
endmodule

bind charger_ctl charger_ctl_asserts u_chk (.*);

// ==== verification/charger_ctl_test.sv ====
/* Bench for charger_ctl: registers, limit choice, gating, alert and irq.
 Assumes the checker is bound in and pins settle within 6 cycles. */
`timescale 1ns/1ps
module charger_ctl_test;
  reg         clk_sys, nrst, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  reg         s_axi_arvalid, s_axi_rready, source_select_in, boost_select_in;
  reg         charge_enable_n_in, ship_exit_in, thermistor_sense, charge_done_in;
  reg         fault_in;
  reg  [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, rd;
  reg  [3:0]  s_axi_wstrb;
  reg  [2:0]  input_limit_resistor_pin;
  reg  [1:0]  rsp;
  reg  [15:0] rows [0:6];
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire        stat_out, stat_oe, alert_out, alert_oe, charge_en_out, boost_en_out;
  wire        battery_switch, irq, stat_pin, alert_pin;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [2:0]  input_current_limit;
  integer     errors, total_checks, i, n;
  charger_ctl dut (.*);
  charger_host_pins host (.*);
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  task test_done;
    begin
      if (errors == 0 && total_checks > 0) begin
        $display("[ PASS ]");
      end else begin
        $display("[ FAIL ]");
      end
      $finish;
    end
  endtask
  task chk_val(input [31:0] got, input [31:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task step(input integer lim);
    begin
      @(posedge clk_sys);
      n = n + 1;
      if (n > lim) begin
        errors = errors + 1;
        test_done;
      end
    end
  endtask
  task settle;
    repeat (6) @(posedge clk_sys);
  endtask
  // Both channels offered together; each dropped once taken
  task axi_wr(input [7:0] a, input [31:0] d);
    begin
      s_axi_awaddr <= {24'h00_0000, a};
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      n = 0;
      rsp = 2'b11;
      while (rsp === 2'b11) begin
        step(50);
        if (s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wready) s_axi_wvalid <= 1'b0;
        if (s_axi_bvalid) begin
          rsp = s_axi_bresp;
          s_axi_bready <= 1'b0;
        end
      end
      @(posedge clk_sys);
    end
  endtask
  task axi_rd(input [7:0] a);
    begin
      s_axi_araddr <= {24'h00_0000, a};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      n = 0;
      rsp = 2'b11;
      while (rsp === 2'b11) begin
        step(50);
        if (s_axi_arready) s_axi_arvalid <= 1'b0;
        if (s_axi_rvalid) begin
          rd = s_axi_rdata;
          rsp = s_axi_rresp;
          s_axi_rready <= 1'b0;
        end
      end
      @(posedge clk_sys);
    end
  endtask
  task rd_chk(input [7:0] a, input [31:0] e);
    begin
      axi_rd(a);
      chk_val(rd, e);
    end
  endtask
  initial begin
    {nrst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 5'h00;
    {s_axi_rready, source_select_in, boost_select_in, ship_exit_in} = 4'h0;
    {charge_done_in, fault_in, charge_enable_n_in, thermistor_sense} = 4'h3;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
    s_axi_wstrb = 4'hf;
    input_limit_resistor_pin = 3'h0;
    errors = 0;
    total_checks = 0;
    // {src,boost} pin reg limit
    rows[0] = 16'h0072;
    rows[1] = 16'h0533;
    rows[2] = 16'h0464;
    rows[3] = 16'h0111;
    rows[4] = 16'h3772;
    rows[5] = 16'h2770;
    rows[6] = 16'h3011;
    repeat (8) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    for (i = 0; i < 7; i = i + 1) begin
      axi_wr(8'h00, {29'h0, rows[i][6:4]});
      source_select_in <= rows[i][13];
      boost_select_in <= rows[i][12];
      input_limit_resistor_pin <= rows[i][10:8];
      settle;
      chk_val({29'h0, input_current_limit}, {29'h0, rows[i][2:0]});
      axi_rd(8'h08);
      chk_val({28'h0, rd[7:4]}, {28'h0, rows[i][2:0], rows[i][13]});
    end
    nrst <= 1'b0;
    repeat (8) @(posedge clk_sys);
    nrst <= 1'b1;
    source_select_in <= 1'b0;
    boost_select_in <= 1'b0;
    @(posedge clk_sys);
    rd_chk(8'h00, 32'h0000_0006);
    rd_chk(8'h04, 32'h0000_0010);
    rd_chk(8'h14, 32'h0000_0000);
    rd_chk(8'h1c, 32'h0000_0000);
    chk_val({30'h0, rsp}, 32'h0000_0002);
    axi_wr(8'h1c, 32'h0000_00ff);
    chk_val({30'h0, rsp}, 32'h0000_0002);
    charge_enable_n_in <= 1'b0;
    settle;
    chk_val(charge_en_out, 1'b1);
    chk_val(stat_pin, 1'b0);
    charge_done_in <= 1'b1;
    settle;
    chk_val(stat_pin, 1'b1);
    charge_done_in <= 1'b0;
    charge_enable_n_in <= 1'b1;
    settle;
    chk_val(charge_en_out, 1'b0);
    charge_enable_n_in <= 1'b0;
    axi_wr(8'h04, 32'h0000_0030);
    settle;
    chk_val({charge_en_out, boost_en_out}, 2'b00);
    boost_select_in <= 1'b1;
    settle;
    chk_val(boost_en_out, 1'b1);
    thermistor_sense <= 1'b0;
    settle;
    chk_val(boost_en_out, 1'b0);
    axi_wr(8'h04, 32'h0000_0010);
    settle;
    chk_val(charge_en_out, 1'b0);
    thermistor_sense <= 1'b1;
    charge_enable_n_in <= 1'b1;
    settle;
    n = 0;
    while (alert_oe !== 1'b0) step(14000);
    axi_wr(8'h18, 32'h0000_000f);
    axi_wr(8'h14, 32'h0000_0002);
    fault_in <= 1'b1;
    n = 0;
    while (alert_oe !== 1'b1) step(20);
    chk_val(stat_pin, 1'b0);
    chk_val(alert_pin, 1'b0);
    n = 0;
    while (alert_oe === 1'b1) step(14000);
    chk_val(n, 32'd12800);
    chk_val(irq, 1'b1);
    rd_chk(8'h10, 32'h0000_0002);
    axi_wr(8'h14, 32'h0000_0000);
    settle;
    chk_val(irq, 1'b0);
    axi_wr(8'h14, 32'h0000_0002);
    settle;
    chk_val(irq, 1'b1);
    axi_wr(8'h18, 32'h0000_0002);
    settle;
    chk_val(irq, 1'b0);
    fault_in <= 1'b0;
    settle;
    chk_val(stat_pin, 1'b1);
    charge_enable_n_in <= 1'b0;
    settle;
    chk_val(stat_pin, 1'b0);
    // Full 2 ms hold would exceed the run budget; left to the checker
    ship_exit_in <= 1'b1;
    repeat (1000) @(posedge clk_sys);
    ship_exit_in <= 1'b0;
    settle;
    chk_val(battery_switch, 1'b0);
    test_done;
  end
endmodule

// ==== verification/charger_host_pins.sv ====
/* Host side of the open-drain status and alert lines.
 Assumes board pull-ups; a released line reads high. */
`timescale 1ns/1ps
module charger_host_pins (
  input  wire stat_out,
  input  wire stat_oe,
  input  wire alert_out,
  input  wire alert_oe,
  output wire stat_pin,
  output wire alert_pin
);
  assign stat_pin  = stat_oe ? stat_out : 1'b1;
  assign alert_pin = alert_oe ? alert_out : 1'b1;
endmodule

// ==== verilog/charger_ctl.v ====
/*
 Digital control and status logic of a single-cell charger: status and alert
 pins, charge and boost gating, input current limit choice, thermistor gating
 and shipping-mode exit. Registers sit behind an AXI4-Lite slave. Assumes all
 pin inputs are asynchronous to clk_sys and that fault and temperature levels
 come from analog comparators.
*/
// Added by the designer: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "charger_ctl_map.vh"

// What this block does
// - Status pin pulled low during charging, released when done or disabled.
// - Any fault makes the status pin blink at 1 Hz, overriding charge indication.
// - Status change or fault gives one 256 us low pulse on the alert pin.
// - USB host buck mode: limit at most 500 mA if boost select high, else 100 mA.
// - Boost mode only with config bit 5 set and boost select high.
// - Charging only with config bits 5:4 equal 01 and charge enable low.
// - Effective input limit is the smaller of resistor pin and register limit.
// - Resistor pin limit never below 500 mA.
// - Thermistor out of window suspends charging or disables boost.
// - Ship exit rising edge held high 2 ms turns battery switch on.
// - Source select high means USB host, low means adapter.
module charger_ctl (
  input  wire        clk_sys,
  input  wire        nrst,
  input  wire [31:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [31:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        source_select_in,
  input  wire        boost_select_in,
  input  wire        charge_enable_n_in,
  input  wire        ship_exit_in,
  input  wire        thermistor_sense,
  input  wire        charge_done_in,
  input  wire        fault_in,
  input  wire [2:0]  input_limit_resistor_pin,
  output reg         stat_out,
  output reg         stat_oe,
  output reg         alert_out,
  output reg         alert_oe,
  output reg         charge_en_out,
  output reg         boost_en_out,
  output reg  [2:0]  input_current_limit,
  output reg         battery_switch,
  output reg         irq
);

  localparam [31:0] BLINK_HALF = `BLINK_HALF_CYC;
  localparam [31:0] ALERT_LEN  = `ALERT_CYC;
  localparam [31:0] SHIP_LEN   = `SHIP_CYC;

  localparam [2:0] SH_IDLE = 3'b001;
  localparam [2:0] SH_WAIT = 3'b010;
  localparam [2:0] SH_DONE = 3'b100;

  function [7:0] apply_strb;
    input [7:0] old;
    input [31:0] wd;
    input [3:0]  st;
    begin
      apply_strb = st[0] ? wd[7:0] : old;
    end
  endfunction

  function [2:0] min3;
    input [2:0] a;
    input [2:0] b;
    begin
      min3 = (a < b) ? a : b;
    end
  endfunction

  // Two-flop synchronisers, nothing reads the first stage but the second
  reg [7:0] sync1_reg;
  reg [7:0] sync2_reg;
  reg [2:0] ilim1_reg;
  reg [2:0] ilim2_reg;
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sync1_reg <= `SYNC_RST; // Avoids a false temperature edge after reset
      sync2_reg <= `SYNC_RST;
      ilim1_reg <= 3'h0;
      ilim2_reg <= 3'h0;
    end else begin
      sync1_reg <= {1'b0, input_limit_resistor_pin[0], fault_in, charge_done_in,
                    thermistor_sense, ship_exit_in, charge_enable_n_in,
                    boost_select_in ^ 1'b0};
      sync2_reg <= sync1_reg;
      ilim1_reg <= input_limit_resistor_pin;
      ilim2_reg <= ilim1_reg;
    end
  end
  reg       src_sel1_reg;
  reg       src_sel2_reg;
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      src_sel1_reg <= 1'b0;
      src_sel2_reg <= 1'b0;
    end else begin
      src_sel1_reg <= source_select_in;
      src_sel2_reg <= src_sel1_reg;
    end
  end

  wire boost_sel  = sync2_reg[0];
  wire ce_n       = sync2_reg[1]; // Relies on a driven level
  wire ship_in    = sync2_reg[2];
  wire temp_ok    = sync2_reg[3];
  wire chg_done   = sync2_reg[4];
  wire fault      = sync2_reg[5];
  wire usb_host   = src_sel2_reg;

  reg [7:0] input_source_reg;
  reg [7:0] charger_config_reg;
  reg [`IRQ_BITS-1:0] irq_status_reg;
  reg [`IRQ_BITS-1:0] irq_enable_reg;

  // Gating of charge and boost
  wire boost_mode = charger_config_reg[`CFG_BOOST_BIT] & boost_sel;
  wire chg_allow  = (charger_config_reg[`CFG_CHG_LSB+1:`CFG_CHG_LSB] == `CFG_CHG_ON)
                    & ~ce_n;
  wire charging   = chg_allow & temp_ok & ~chg_done & ~fault;

  // Resistor limit clamped up to 500 mA code, then min with register
  wire [2:0] input_limit_resistor_pin_pin  = (ilim2_reg < `INPUT_LIMIT_RESISTOR_PIN_500) ? `INPUT_LIMIT_RESISTOR_PIN_500 : ilim2_reg;
  wire [2:0] input_limit_resistor_pin_eff  = min3(input_limit_resistor_pin_pin, input_source_reg[2:0]);
  wire [2:0] input_limit_resistor_pin_usb  = boost_sel ? `INPUT_LIMIT_RESISTOR_PIN_500 : `INPUT_LIMIT_RESISTOR_PIN_100;
  wire [2:0] input_limit_resistor_pin_next = usb_host ? min3(input_limit_resistor_pin_usb, input_limit_resistor_pin_eff) : input_limit_resistor_pin_eff;

  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      charge_en_out       <= 1'b0;
      boost_en_out        <= 1'b0;
      input_current_limit <= `INPUT_LIMIT_RESISTOR_PIN_100;
    end else begin
      charge_en_out       <= charging & ~boost_mode;
      boost_en_out        <= boost_mode & temp_ok;
      input_current_limit <= input_limit_resistor_pin_next;
    end
  end

  // Blink timer, equal halves; cleared while no fault so each blink starts with the pin low
  reg [31:0] blink_cnt_reg;
  reg        blink_reg;
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      blink_cnt_reg <= 32'h0000_0000;
      blink_reg     <= 1'b0;
    end else if (!fault) begin
      blink_cnt_reg <= 32'h0000_0000;
      blink_reg     <= 1'b0;
    end else if (blink_cnt_reg == BLINK_HALF - 32'h0000_0001) begin
      blink_cnt_reg <= 32'h0000_0000;
      blink_reg     <= ~blink_reg;
    end else begin
      blink_cnt_reg <= blink_cnt_reg + 32'h0000_0001;
    end
  end

  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      stat_out <= 1'b0;
      stat_oe  <= 1'b0;
    end else begin
      stat_out <= 1'b0;
      stat_oe  <= fault ? ~blink_reg : charging;
    end
  end

  // Status events
  reg prev_charging_reg;
  reg prev_fault_reg;
  reg prev_temp_reg;
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      prev_charging_reg <= 1'b0;
      prev_fault_reg    <= 1'b0;
      prev_temp_reg     <= 1'b1;
    end else begin
      prev_charging_reg <= charging;
      prev_fault_reg    <= fault;
      prev_temp_reg     <= temp_ok;
    end
  end
  wire ev_chg   = charging ^ prev_charging_reg;
  wire ev_fault = fault & ~prev_fault_reg;
  wire ev_temp  = temp_ok ^ prev_temp_reg;

  // Ship exit qualifier
  reg [2:0]  ship_state_reg;
  reg [31:0] ship_cnt_reg;
  reg        ship_prev_reg;
  reg        ev_ship_reg;
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ship_state_reg <= SH_IDLE;
      ship_cnt_reg   <= 32'h0000_0000;
      ship_prev_reg  <= 1'b1;
      battery_switch <= 1'b0;
      ev_ship_reg    <= 1'b0;
    end else begin
      ship_prev_reg <= ship_in;
      ev_ship_reg   <= 1'b0;
      case (ship_state_reg)
        SH_IDLE: begin
          if (ship_in && !ship_prev_reg) begin
            ship_cnt_reg   <= 32'h0000_0000;
            ship_state_reg <= SH_WAIT;
          end
        end
        SH_WAIT: begin
          if (!ship_in) begin
            ship_state_reg <= SH_IDLE;
          end else if (ship_cnt_reg == SHIP_LEN - 32'h0000_0001) begin
            battery_switch <= 1'b1;
            ev_ship_reg    <= 1'b1;
            ship_state_reg <= SH_DONE;
          end else begin
            ship_cnt_reg <= ship_cnt_reg + 32'h0000_0001;
          end
        end
        SH_DONE: begin
          ship_state_reg <= SH_DONE;
        end
        default: begin
          ship_state_reg <= SH_IDLE;
        end
      endcase
    end
  end

  // Alert pulse; events during a pulse merge into it
  reg [31:0] alert_cnt_reg;
  wire       alert_ev = ev_chg | ev_fault | ev_temp | ev_ship_reg;
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      alert_cnt_reg <= 32'h0000_0000;
      alert_out     <= 1'b0;
      alert_oe      <= 1'b0;
    end else begin
      alert_out <= 1'b0;
      if (alert_cnt_reg != 32'h0000_0000) begin
        alert_cnt_reg <= alert_cnt_reg - 32'h0000_0001;
        alert_oe      <= (alert_cnt_reg != 32'h0000_0001);
      end else if (alert_ev) begin
        alert_cnt_reg <= ALERT_LEN;
        alert_oe      <= 1'b1;
      end else begin
        alert_oe <= 1'b0;
      end
    end
  end

  // AXI4-Lite slave, one write and one read at a time
  reg        aw_hold_reg;
  reg        w_hold_reg;
  reg [7:0]  aw_addr_reg;
  reg [31:0] w_data_reg;
  reg [3:0]  w_strb_reg;
  wire       do_write = aw_hold_reg & w_hold_reg & ~s_axi_bvalid;
  wire [`IRQ_BITS-1:0] ev_vec = {ev_temp, ev_ship_reg, ev_fault, ev_chg};
  reg  [`IRQ_BITS-1:0] clr_vec;

  always @* begin
    clr_vec = {`IRQ_BITS{1'b0}};
    if (do_write && aw_addr_reg == `OFF_IRQ_CLEAR && w_strb_reg[0]) begin
      clr_vec = w_data_reg[`IRQ_BITS-1:0];
    end
  end

  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s_axi_awready      <= 1'b1;
      s_axi_wready       <= 1'b1;
      s_axi_bvalid       <= 1'b0;
      s_axi_bresp        <= `RESP_OKAY;
      aw_hold_reg        <= 1'b0;
      w_hold_reg         <= 1'b0;
      aw_addr_reg        <= 8'h00;
      w_data_reg         <= 32'h0000_0000;
      w_strb_reg         <= 4'h0;
      input_source_reg   <= `INPUT_SOURCE_RST;
      charger_config_reg <= `CHARGER_CONFIG_RST;
      irq_enable_reg     <= `IRQ_ENABLE_RST;
      irq_status_reg     <= {`IRQ_BITS{1'b0}};
      irq                <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_reg   <= 1'b1;
        aw_addr_reg   <= s_axi_awaddr[7:0];
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_reg   <= 1'b1;
        w_data_reg   <= s_axi_wdata;
        w_strb_reg   <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        aw_hold_reg  <= 1'b0;
        w_hold_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `RESP_OKAY;
        case (aw_addr_reg)
          `OFF_INPUT_SOURCE:
            input_source_reg <= apply_strb(input_source_reg, w_data_reg, w_strb_reg);
          `OFF_CHARGER_CONFIG:
            charger_config_reg <= apply_strb(charger_config_reg, w_data_reg, w_strb_reg);
          `OFF_IRQ_ENABLE:
            irq_enable_reg <= w_strb_reg[0] ? w_data_reg[`IRQ_BITS-1:0] : irq_enable_reg;
          `OFF_IRQ_CLEAR, `OFF_STATUS, `OFF_FAULT, `OFF_IRQ_STATUS: begin
          end
          default: s_axi_bresp <= `RESP_SLVERR;
        endcase
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
      // Set wins over a clear in the same cycle
      irq_status_reg <= (irq_status_reg & ~clr_vec) | ev_vec;
      irq            <= |(((irq_status_reg & ~clr_vec) | ev_vec) & irq_enable_reg);
    end
  end

  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= `RESP_OKAY;
        case (s_axi_araddr[7:0])
          `OFF_INPUT_SOURCE:   s_axi_rdata <= {24'h00_0000, input_source_reg};
          `OFF_CHARGER_CONFIG: s_axi_rdata <= {24'h00_0000, charger_config_reg};
          `OFF_STATUS:         s_axi_rdata <= {23'h00_0000, battery_switch,
                                               input_current_limit, usb_host,
                                               boost_en_out, charge_en_out,
                                               charging, 1'b0};
          `OFF_FAULT:          s_axi_rdata <= {30'h0000_0000, ~temp_ok, fault};
          `OFF_IRQ_STATUS:     s_axi_rdata <= {28'h000_0000, irq_status_reg};
          `OFF_IRQ_ENABLE:     s_axi_rdata <= {28'h000_0000, irq_enable_reg};
          `OFF_IRQ_CLEAR:      s_axi_rdata <= 32'h0000_0000;
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule

// ==== verilog/charger_ctl_map.vh ====
/*
 Register offsets, field positions, reset values and timing counts for the
 charger pin control block. Assumes a 50 MHz system clock.
*/
`ifndef CHARGER_CTL_MAP_VH
`define CHARGER_CTL_MAP_VH

`define CLK_HZ              50000000
`define BLINK_HZ            1
`define BLINK_HALF_CYC      (`CLK_HZ / (2 * `BLINK_HZ))
`define ALERT_US            256
`define ALERT_CYC           ((`ALERT_US * (`CLK_HZ / 1000000)))
`define SHIP_MS             2
`define SHIP_CYC            ((`SHIP_MS * (`CLK_HZ / 1000)))

`define OFF_INPUT_SOURCE    8'h00
`define OFF_CHARGER_CONFIG  8'h04
`define OFF_STATUS          8'h08
`define OFF_FAULT           8'h0C
`define OFF_IRQ_STATUS      8'h10
`define OFF_IRQ_ENABLE      8'h14
`define OFF_IRQ_CLEAR       8'h18

`define INPUT_SOURCE_RST    8'h06
`define CHARGER_CONFIG_RST  8'h10
`define IRQ_ENABLE_RST      4'h0
// Idle pin levels: temperature in window, charge enable released
`define SYNC_RST            8'h0A

`define CFG_BOOST_BIT       5
`define CFG_CHG_LSB         4
`define CFG_CHG_ON          2'b01

`define INPUT_LIMIT_RESISTOR_PIN_100            3'h0
`define INPUT_LIMIT_RESISTOR_PIN_500            3'h2

`define IRQ_STATUS_CHG      0
`define IRQ_FAULT           1
`define IRQ_SHIP_EXIT       2
`define IRQ_TEMP            3
`define IRQ_BITS            4

`define RESP_OKAY           2'b00
`define RESP_SLVERR         2'b10

`endif
